// file: lssw_pkg.sv
`default_nettype none
package lssw_pkg;

  // Frequencies are carried in 0.1 Hz units
  localparam int unsigned FREQ_W          = 16;
  localparam int unsigned THR_W           = 17;
  // Timeout is carried in 0.1 s units
  localparam int unsigned TMO_W           = 14;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned TICK_TIME_NS    = 100_000_000;
  localparam int unsigned TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0]  OFS_TIMEOUT     = 8'h00;
  localparam logic [7:0]  OFS_OFFSET      = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_ELAPSED     = 8'h0C;

  // Reset values and setting limits
  localparam logic [TMO_W-1:0]  TMO_RST   = 14'h0000;
  localparam logic [TMO_W-1:0]  TMO_MAX   = 14'h270F;
  localparam logic [FREQ_W-1:0] OFFS_RST  = 16'h000A;
  localparam logic [FREQ_W-1:0] OFFS_MIN  = 16'h000A;

  // Status register field positions
  localparam int unsigned ST_SLEEP_BIT    = 0;
  localparam int unsigned ST_TIMING_BIT   = 1;
  localparam int unsigned ST_BELOW_BIT    = 2;
  localparam int unsigned ST_SPDMODE_BIT  = 3;
  localparam int unsigned ST_THR_POS      = 16;

  typedef enum logic [1:0] {
    LSSW_IDLE,
    LSSW_TIMING,
    LSSW_SLEEP
  } lssw_state_e;

  // Inputs from the reference chain and run source
  typedef struct packed {
    logic [FREQ_W-1:0] pre_ramp_ref;
    logic [FREQ_W-1:0] output_freq;
    logic [FREQ_W-1:0] low_speed_floor;
    logic [FREQ_W-1:0] max_freq;
    logic              run_cmd;
    logic              pid_active;
  } lssw_drive_s;

  // Commands toward the ramp generator
  typedef struct packed {
    logic ramp_stop;
    logic freewheel_stop;
    logic sleeping;
  } lssw_ctl_s;

endpackage : lssw_pkg
`default_nettype wire

// file: lssw_tick.sv
`timescale 1ns/100ps
`default_nettype none
module lssw_tick #(
  parameter int unsigned CYCLES = 5_000_000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic clr,
  output logic      tick
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_ff;

  // Free divider, restarted so a timing window begins on a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (clr || cnt_ff == LAST) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  assign tick = ce && !clr && (cnt_ff == LAST);

endmodule : lssw_tick
`default_nettype wire

// file: lssw_top.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// (R1) Act only while PID is inactive
// (R2) Stop after both frequencies stay below threshold
// (R3) Stop on active deceleration ramp, never freewheel
// (R4) Abandon wait if either frequency rises above
// (R5) Restart when reference above threshold and running
// (R6) Timeout in 0.1 s steps, 999.9 s, reset zero
// (R7) Offset from 1.0 Hz to max, reset 1.0
// (R8) One threshold for sleep entry and restart
// (R9) Zero timeout disables sleep entirely
module lssw_top
  import lssw_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire lssw_drive_s drive,
  output lssw_ctl_s        ctl
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Settings written by software
  logic [TMO_W-1:0]  timeout_ff;
  logic [FREQ_W-1:0] offset_ff;

  // Sequencer state and elapsed window time
  logic [TMO_W-1:0]  elapsed_ff;
  logic [TMO_W-1:0]  nxt_elapsed;
  lssw_state_e       state_ff;
  lssw_state_e       nxt_state;

  // Stop commands toward the ramp generator
  logic              ramp_stop_ff;
  logic              sleeping_ff;

  // Register interface
  logic [31:0]       rdata_ff;
  logic [31:0]       rd_mux;
  logic [31:0]       status_word;
  logic              rd_hit;
  logic              setup;
  logic              wr_acc;
  logic              wr_timeout;
  logic              wr_offset;
  logic [TMO_W-1:0]  wr_tmo;
  logic [FREQ_W-1:0] wr_offs;
  logic [FREQ_W-1:0] offs_max;

  // Speed comparison against the shared threshold
  logic [THR_W-1:0]  threshold;
  logic              ref_below;
  logic              out_below;
  logic              both_below;
  logic              ref_above;
  logic              spd_mode;
  logic              armed;
  logic              may_sleep;

  // Time base
  logic              tick;
  logic              tick_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Speed condition

  // Function is live only when PID is not steering the speed
  assign spd_mode = !drive.pid_active; // R1

  // Zero timeout leaves the function switched off
  assign armed = spd_mode && (timeout_ff != TMO_RST); // R9

  // Run command still present and function armed
  assign may_sleep = armed && drive.run_cmd; // R5

  // Floor plus offset, one sum for entry and for restart
  // One bit wider so the sum can never wrap
  assign threshold = {1'b0, drive.low_speed_floor} + {1'b0, offset_ff}; // R8

  // Strict comparisons against the shared threshold
  // Equal to the threshold counts as neither below nor above
  assign ref_below  = {1'b0, drive.pre_ramp_ref} < threshold;
  assign out_below  = {1'b0, drive.output_freq} < threshold;
  assign both_below = ref_below && out_below; // R2
  assign ref_above  = {1'b0, drive.pre_ramp_ref} > threshold; // R5

  //////////////////////////////////////////////////////////////////////////////
  // Time base

  // Divider restarts whenever a timing window is not running,
  // so the first tick of a window comes a full 0.1 s after it opens
  assign tick_clr = (state_ff != LSSW_TIMING);

  lssw_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (tick_clr),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer

  // Next state and elapsed count
  always_comb begin
    nxt_state   = state_ff;
    nxt_elapsed = elapsed_ff;
    unique case (state_ff)
      // Waiting for both frequencies to drop below the threshold
      LSSW_IDLE: begin
        nxt_elapsed = '0;
        if (may_sleep && both_below) begin
          nxt_state = LSSW_TIMING; // R2
        end
      end
      // Counting low speed time in 0.1 s ticks
      LSSW_TIMING: begin
        if (!may_sleep) begin
          nxt_state = LSSW_IDLE; // R1
        end else if (!both_below) begin
          nxt_state = LSSW_IDLE; // R4
        end else if (tick) begin
          nxt_elapsed = elapsed_ff + TMO_W'(1);
          // A timeout lowered under the count ends the wait at the next tick
          if (nxt_elapsed >= timeout_ff) begin
            nxt_state = LSSW_SLEEP; // R2
          end
        end
      end
      // Motor held stopped until the reference climbs back or may_sleep falls
      LSSW_SLEEP: begin
        if (!may_sleep) begin
          nxt_state = LSSW_IDLE; // R9
        end else if (ref_above) begin
          nxt_state = LSSW_IDLE; // R5
        end
      end
      // Unused code falls back to waiting
      default: begin
        nxt_state   = LSSW_IDLE;
        nxt_elapsed = '0;
      end
    endcase
  end

  // State register
  // Frozen with the rest of the sequencer while the enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= LSSW_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Elapsed time in 0.1 s units
  // Cleared whenever the sequencer waits, so each window starts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_ff <= '0;
    end else if (ce) begin
      elapsed_ff <= nxt_elapsed;
    end
  end

  // Ramp stop held for as long as the motor sleeps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_stop_ff <= 1'b0;
    end else if (ce) begin
      ramp_stop_ff <= (nxt_state == LSSW_SLEEP); // R3
    end
  end

  // Sleep flag, a separate register loaded with the same value as the ramp command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping_ff <= 1'b0;
    end else if (ce) begin
      sleeping_ff <= (nxt_state == LSSW_SLEEP);
    end
  end

  // Freewheel is never requested: sleep always uses the active ramp
  assign ctl = '{ramp_stop: ramp_stop_ff, freewheel_stop: 1'b0, sleeping: sleeping_ff}; // R3

  //////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Map: timeout, offset, status and elapsed time, one word each.
  // Writes to the two read-only words are dropped without an error.
  // Writes land at the access edge and are lost while frozen.
  assign setup      = psel && !penable;
  assign wr_acc     = psel && penable && pwrite && ce;
  assign wr_timeout = wr_acc && (paddr == OFS_TIMEOUT);
  assign wr_offset  = wr_acc && (paddr == OFS_OFFSET);

  // Zero wait states; unmapped offsets answer with an error
  // The slave never stretches a transfer
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // Timeout write saturates at 999.9 s
  // Values above the top of the range are pinned, not wrapped
  always_comb begin
    wr_tmo = pwdata[TMO_W-1:0];
    if (pwdata[31:TMO_W] != '0 || pwdata[TMO_W-1:0] > TMO_MAX) begin
      wr_tmo = TMO_MAX; // R6
    end
  end

  // Offset write held between 1.0 Hz and the maximum frequency
  // Upper limit follows the drive's maximum frequency input
  always_comb begin
    offs_max = (drive.max_freq < OFFS_MIN) ? OFFS_MIN : drive.max_freq;
    wr_offs  = pwdata[FREQ_W-1:0];
    if (pwdata[31:FREQ_W] != '0 || pwdata[FREQ_W-1:0] > offs_max) begin
      wr_offs = offs_max; // R7
    end else if (pwdata[FREQ_W-1:0] < OFFS_MIN) begin
      wr_offs = OFFS_MIN; // R7
    end
  end

  // Low speed timeout register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_ff <= TMO_RST; // R6
    end else if (wr_timeout) begin
      timeout_ff <= wr_tmo;
    end
  end

  // Sleep offset register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_ff <= OFFS_RST; // R7
    end else if (wr_offset) begin
      offset_ff <= wr_offs;
    end
  end

  // Status word: state, speed condition and threshold in 0.2 Hz units
  always_comb begin
    status_word                   = '0;
    status_word[ST_SLEEP_BIT]     = (state_ff == LSSW_SLEEP);
    status_word[ST_TIMING_BIT]    = (state_ff == LSSW_TIMING);
    status_word[ST_BELOW_BIT]     = both_below;
    status_word[ST_SPDMODE_BIT]   = spd_mode;
    status_word[ST_THR_POS +: 16] = threshold[THR_W-1:1];
  end

  // Read decode
  // Unmapped offsets read zero and raise the error flag
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      OFS_TIMEOUT: begin
        rd_mux[TMO_W-1:0] = timeout_ff;
      end
      OFS_OFFSET: begin
        rd_mux[FREQ_W-1:0] = offset_ff;
      end
      OFS_STATUS: begin
        rd_mux = status_word;
      end
      OFS_ELAPSED: begin
        rd_mux[TMO_W-1:0] = elapsed_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data captured in the setup cycle
  // Left live under a low enable so software can still look
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (setup && !pwrite) begin
      rdata_ff <= rd_mux;
    end
  end

  assign prdata = rdata_ff;

endmodule : lssw_top
`default_nettype wire

// file: lssw_drv_model.sv
`timescale 1ns/100ps
`default_nettype none
module lssw_drv_model
  import lssw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] ref_hz,
  input  wire logic [15:0] floor_hz,
  input  wire logic        run,
  input  wire logic        pid,
  input  wire logic        boost,
  input  wire lssw_ctl_s   ctl,
  output lssw_drive_s      drive
);
  logic [15:0] outf_ff;
  // Output frequency lags the target by a cycle and falls to zero on a ramp stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      outf_ff <= 16'h0000;
    else
      outf_ff <= ctl.ramp_stop ? 16'h0000 : (boost ? 16'h01F4 : ref_hz);
  end
  // Maximum frequency fixed at 50 Hz
  assign drive = '{ref_hz, outf_ff, floor_hz, 16'h01F4, run, pid};
endmodule : lssw_drv_model
`default_nettype wire

// file: lssw_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lssw_asserts
  import lssw_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire lssw_drive_s drive,
  input wire lssw_ctl_s   ctl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [16:0] hi_lim;
  // Highest threshold the offset clamp allows
  assign hi_lim = {1'b0, drive.low_speed_floor} + ((drive.max_freq < 16'h000A) ? 17'h0_000A : {1'b0, drive.max_freq});
  a_no_freewheel: assert property (!ctl.freewheel_stop) else $error("freewheel stop");
  a_ramp_sleep: assert property (ctl.ramp_stop == ctl.sleeping) else $error("ramp stop differs");
  a_pid_run_off: assert property (ce && (drive.pid_active || !drive.run_cmd) |=> !ctl.sleeping)
    else $error("asleep in pid mode or without run");
  a_hi_ref_wake: assert property (ce && ({1'b0, drive.pre_ramp_ref} > hi_lim) |=> !ctl.sleeping)
    else $error("asleep with high reference");
  a_hi_outf: assert property (ce && !ctl.sleeping && ({1'b0, drive.output_freq} > hi_lim) |=> !ctl.sleeping)
    else $error("slept with high output");
  a_rise_ce: assert property ($rose(ctl.sleeping) |-> $past(ce)) else $error("slept while frozen");
  a_wake_ce: assert property ($fell(ctl.sleeping) |-> $past(ce)) else $error("woke while frozen");
  a_bad_addr: assert property (psel && penable |-> pready && (pslverr == (paddr > 8'h0C || paddr[1:0] != 2'b00)))
    else $error("bad error flag");
endmodule : lssw_asserts
bind lssw_top lssw_asserts u_chk(.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive(drive), .ctl(ctl));
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb;
  import lssw_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, run, pid, boost;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] refv, flr;
  lssw_drive_s drive;
  lssw_ctl_s   ctl;
  int          fails, compares, n;
  lssw_top #(.TICK_CYC(4)) dut(.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive(drive), .ctl(ctl));
  lssw_drv_model u_drv(.pclk(pclk), .presetn(presetn), .ref_hz(refv), .floor_hz(flr), .run(run), .pid(pid),
    .boost(boost), .ctl(ctl), .drive(drive));
  // Clock at 50 MHz
  always #10 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // One APB transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin fails++; end_sim(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Bounded wait for the sleep flag
  task automatic wsl(input logic e, input int lim);
    n = 0;
    while (ctl.sleeping !== e && n < lim) begin @(posedge pclk); n++; end
    `CHK(ctl.sleeping, e)
    if (ctl.sleeping !== e) end_sim();
  endtask : wsl
  ////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    refv = 16'h0032; flr = 16'h0064; run = 1; pid = 0; boost = 0; fails = 0; compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_TIMEOUT, 0); `CHK(rd[13:0], TMO_RST)
    apb(0, OFS_OFFSET, 0); `CHK(rd[15:0], OFFS_RST)
    apb(0, 8'h10, 0); `CHK(err, 1'b1)
    repeat (40) @(posedge pclk);
    `CHK(ctl.sleeping, 1'b0)
    $display("test reset done");
    refv <= 16'h00C8;
    apb(1, OFS_TIMEOUT, 32'h0000_0002);
    refv <= 16'h0032;
    wsl(1, 40); `CHK(n >= 10 && n <= 14, 1'b1)
    `CHK(ctl.ramp_stop, 1'b1)
    refv <= 16'h006E;
    repeat (10) @(posedge pclk);
    `CHK(ctl.sleeping, 1'b1)
    refv <= 16'h006F;
    wsl(0, 4);
    refv <= 16'h0032;
    wsl(1, 40);
    run <= 1'b0;
    wsl(0, 4);
    run <= 1'b1;
    refv <= 16'h00C8;
    repeat (4) @(posedge pclk);
    $display("test sleep done");
    // Abort by output, then by reference
    for (int k = 0; k < 2; k++) begin
      refv <= 16'h0032; boost <= 1'b0;
      repeat (6) @(posedge pclk);
      if (k == 0) boost <= 1'b1; else refv <= 16'h00C8;
      repeat (30) @(posedge pclk);
      `CHK(ctl.sleeping, 1'b0)
    end
    $display("test abort done");
    refv <= 16'h0032; pid <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK(ctl.sleeping, 1'b0)
    pid <= 1'b0;
    wsl(1, 40);
    apb(1, OFS_TIMEOUT, 0);
    wsl(0, 6);
    apb(1, OFS_OFFSET, 1);
    apb(0, OFS_OFFSET, 0); `CHK(rd[15:0], OFFS_MIN)
    apb(1, OFS_TIMEOUT, 32'h0001_0000);
    apb(0, OFS_TIMEOUT, 0); `CHK(rd[13:0], TMO_MAX)
    apb(0, OFS_STATUS, 0); `CHK(rd, 32'h0037_000E)
    apb(0, OFS_ELAPSED, 0); `CHK(rd[13:0] != 14'h0000, 1'b1)
    $display("test mode done");
    // Low enable freezes writes and the sequencer
    apb(1, OFS_TIMEOUT, 0);
    ce <= 1'b0;
    apb(1, OFS_TIMEOUT, 32'h0000_0002);
    apb(0, OFS_TIMEOUT, 0); `CHK(rd[13:0], TMO_RST)
    repeat (30) @(posedge pclk);
    `CHK(ctl.sleeping, 1'b0)
    ce <= 1'b1;
    apb(1, OFS_TIMEOUT, 32'h0000_0002);
    wsl(1, 40);
    ce <= 1'b0; refv <= 16'h006F;
    repeat (10) @(posedge pclk);
    `CHK(ctl.sleeping, 1'b1)
    ce <= 1'b1;
    wsl(0, 4);
    $display("test enable done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
